// File: rtl/psrc_pkg.sv
// Purpose: Shared constants and types for the pin sleep and reset state control block.
// Assumes: One 20 MHz clock; registers on APB with 32-bit data.
// Notes:   Offsets are byte addresses of aligned words.
package psrc_pkg;

   // Pin and sleep-state register counts.
   localparam int GPIO_COUNT = 128;
   localparam int SST_COUNT  = 4;
   localparam int MEM_PINS   = 4;

   // Timing: figures in ns, counts derived and rounded up.
   localparam int CLK_PERIOD_NS = 50;
   localparam int SYS_TO_PWR_NS = 1000;
   localparam int PWR_TO_REL_NS = 2000;
   localparam int SEQ_CNT_W     = 8;
   localparam int SYS_TO_PWR_CYC = (SYS_TO_PWR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PWR_TO_REL_CYC = (PWR_TO_REL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Register offsets.
   localparam logic [11:0] ADDR_SLEEP_STATUS = 12'h000;
   localparam logic [11:0] ADDR_POWER_CFG    = 12'h004;
   localparam logic [11:0] ADDR_SUB_PIN_CTRL = 12'h008;
   localparam logic [11:0] ADDR_OSC_CFG      = 12'h00c;
   localparam logic [11:0] ADDR_SLEEP_STATE0 = 12'h010;
   localparam logic [11:0] ADDR_SLEEP_STATE3 = 12'h01c;

   // Field positions.
   localparam int SSR_SLEEP_BIT = 0;
   localparam int SSR_DEEP_BIT  = 1;
   localparam int SSR_RDH_BIT   = 4;
   localparam int SSR_PERH_BIT  = 5;
   localparam int PCR_SMF_BIT   = 0;
   localparam int PCR_PCF_BIT   = 1;
   localparam int SUB_A_BIT     = 0;
   localparam int SUB_B_BIT     = 1;
   localparam int OSC_PCE_BIT   = 0;
   localparam int OSC_TCE_BIT   = 1;

   // Reset values.
   localparam logic        HOLD_RESET = 1'b1;
   localparam logic [31:0] SST_RESET  = 32'h0000_0000;

   // Pins taken over by clock outputs and the subscriber enable.
   localparam int PIN_PROG_CLK  = 9;
   localparam int PIN_TIMER_CLK = 10;
   localparam int PIN_SUB_A     = 114;
   localparam int PIN_SUB_B     = 115;

   // Power sequencing states.
   typedef enum logic [1:0] {
      SEQ_SYS,
      SEQ_PWR,
      SEQ_RUN
   } psrc_seq_e;

endpackage

// File: rtl/psrc_sync.sv
// Purpose: Two-flop synchroniser for levels from outside the clock domain.
// Assumes: Asynchronous active-low reset.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ns
module psrc_sync #(
   parameter int          W         = 1,
   parameter logic [0:0]  RESET_VAL = 1'b0
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_r;

   // Both stages reset to the same constant.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= {W{RESET_VAL}};
         q      <= {W{RESET_VAL}};
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule // psrc_sync

// File: rtl/psrc_pin_cell.sv
// Purpose: Registered pad control for one multipurpose pin.
// Assumes: All inputs are on ref_clk.
// Notes:   Priority is power manager, low power, forced function, normal.
`timescale 1ns/1ns
module psrc_pin_cell (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic pm_ovr,
   input  wire logic pm_out,
   input  wire logic pm_oe,
   input  wire logic low_power,
   input  wire logic in_sleep,
   input  wire logic sleep_float,
   input  wire logic hold_val,
   input  wire logic hold_oe,
   input  wire logic read_disable_hold,
   input  wire logic pull_up_def,
   input  wire logic pull_dn_def,
   input  wire logic force_en,
   input  wire logic force_val,
   input  wire logic alt_sel,
   input  wire logic alt_out,
   input  wire logic alt_oe,
   input  wire logic gpio_dir,
   input  wire logic gpio_out,
   output logic      pad_out,
   output logic      pad_oe,
   output logic      pad_ie,
   output logic      pad_pu,
   output logic      pad_pd
);

   logic out_nxt;
   logic oe_nxt;
   logic ie_nxt;
   logic pu_nxt;
   logic pd_nxt;

   // Select the pad drive for the current power state.
   always_comb begin
      out_nxt = 1'b0;
      oe_nxt  = 1'b0;
      ie_nxt  = 1'b0;
      pu_nxt  = 1'b0;
      pd_nxt  = 1'b0;
      if (pm_ovr) begin
         // Pulls drop at once and the hold bits are ignored.
         out_nxt = pm_out;
         oe_nxt  = pm_oe;
         ie_nxt  = ~pm_oe;
      end else if (low_power) begin
         // Sleep and post-wake hold drive the captured sleep value; inputs stay undriven.
         out_nxt = hold_val;
         oe_nxt  = hold_oe & ~(in_sleep & sleep_float);
         pu_nxt  = read_disable_hold & ~hold_oe & pull_up_def;
         pd_nxt  = read_disable_hold & ~hold_oe & pull_dn_def;
         ie_nxt  = ~hold_oe & ~read_disable_hold;
      end else if (force_en) begin
         out_nxt = force_val;
         oe_nxt  = 1'b1;
      end else begin
         out_nxt = alt_sel ? alt_out : gpio_out;
         oe_nxt  = alt_sel ? alt_oe : gpio_dir;
         ie_nxt  = ~oe_nxt & ~read_disable_hold;
         pu_nxt  = ~oe_nxt & read_disable_hold & pull_up_def;
         pd_nxt  = ~oe_nxt & read_disable_hold & pull_dn_def;
      end
   end

   // Pad controls leave straight from flops.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pad_out <= 1'b0;
         pad_oe  <= 1'b0;
         pad_ie  <= 1'b0;
         pad_pu  <= 1'b0;
         pad_pd  <= 1'b0;
      end else begin
         pad_out <= out_nxt;
         pad_oe  <= oe_nxt;
         pad_ie  <= ie_nxt;
         pad_pu  <= pu_nxt;
         pad_pd  <= pd_nxt;
      end
   end

endmodule // psrc_pin_cell

// File: rtl/psrc_top.sv
// Purpose: Pad state control of multipurpose pins across reset, sleep and deep sleep.
// Assumes: Power manager requests are on ref_clk; reset_pin_n is a raw pin.
// Notes:   Registers on APB, zero wait states.
// Function
// - Reset: inputs, buffers off, pulled; deep sleep acts as sleep.
// - Sleep outputs drive sleep-state value; inputs undriven.
// - Outputs hold after wake until software clears.
// - Wake inputs stay disabled until read hold clears.
// - Static memory float bit floats pins in sleep.
// - PC-card float bit floats pins in sleep.
// - Power manager override ignores holds, drops pulls.
// - Non-GPIO memory pins float in sleep on static float.
// - Power enable rises after system enable.
// - Subscriber bits force enable onto 114, 115.
// - Clock-output bits force clocks onto 9, 10.
// - Timer-active group stops functioning during sleep.
`timescale 1ns/1ns
module psrc_top
   import psrc_pkg::*;
#(
   parameter logic [GPIO_COUNT-1:0] PULL_UP_MASK    = '0,
   parameter logic [GPIO_COUNT-1:0] PULL_DN_MASK    = '0,
   parameter logic [GPIO_COUNT-1:0] STATIC_MEM_MASK = '0,
   parameter logic [GPIO_COUNT-1:0] PC_CARD_MASK    = '0,
   parameter logic [GPIO_COUNT-1:0] TIMER_STOP_MASK = '0
) (
   input  wire logic                  ref_clk,
   input  wire logic                  resetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  reset_pin_n,
   input  wire logic                  sleep_req,
   input  wire logic                  deep_sleep_req,
   input  wire logic                  os_timer_active,
   input  wire logic [GPIO_COUNT-1:0] pm_override,
   input  wire logic [GPIO_COUNT-1:0] pm_out,
   input  wire logic [GPIO_COUNT-1:0] pm_oe,
   input  wire logic [GPIO_COUNT-1:0] gpio_dir,
   input  wire logic [GPIO_COUNT-1:0] gpio_out,
   input  wire logic [GPIO_COUNT-1:0] alt_sel,
   input  wire logic [GPIO_COUNT-1:0] alt_out,
   input  wire logic [GPIO_COUNT-1:0] alt_oe,
   input  wire logic                  prog_clock_out,
   input  wire logic                  timer_clock_out,
   input  wire logic                  subscriber_enable,
   input  wire logic [MEM_PINS-1:0]   mem_ctl_out,
   input  wire logic [MEM_PINS-1:0]   mem_ctl_oe,
   output logic      [GPIO_COUNT-1:0] pad_out,
   output logic      [GPIO_COUNT-1:0] pad_oe,
   output logic      [GPIO_COUNT-1:0] pad_ie,
   output logic      [GPIO_COUNT-1:0] pad_pu,
   output logic      [GPIO_COUNT-1:0] pad_pd,
   output logic      [MEM_PINS-1:0]   mem_pad_out,
   output logic      [MEM_PINS-1:0]   mem_pad_oe,
   output logic                       system_enable_out,
   output logic                       power_enable_out,
   output logic                       internal_resetn_out
);

   // True for any mapped register word.
   function automatic logic addr_hit(input logic [11:0] a);
      addr_hit = (a == ADDR_SLEEP_STATUS) || (a == ADDR_POWER_CFG) ||
                 (a == ADDR_SUB_PIN_CTRL) || (a == ADDR_OSC_CFG) ||
                 ((a >= ADDR_SLEEP_STATE0) && (a <= ADDR_SLEEP_STATE3) && (a[1:0] == 2'b00));
   endfunction

   logic rst_n;
   logic rst_pin_s_n;

   // Reset is released through two flops; the reset pin is synchronised likewise.
   psrc_sync #(.W(1), .RESET_VAL(1'b0)) u_rst_sync (
      .ref_clk (ref_clk),
      .rst_n   (resetn),
      .d       (1'b1),
      .q       (rst_n)
   );
   psrc_sync #(.W(1), .RESET_VAL(1'b0)) u_pin_sync (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .d       (reset_pin_n),
      .q       (rst_pin_s_n)
   );

   // Power sequencing state.
   psrc_seq_e             seq_r, seq_nxt;
   logic [SEQ_CNT_W-1:0]  cnt_r, cnt_nxt;
   logic                  system_enable_out_nxt, power_enable_out_nxt, irst_n_nxt;

   // System enable first, power enable after a gap, then internal reset release.
   always_comb begin
      seq_nxt    = seq_r;
      cnt_nxt    = cnt_r;
      case (seq_r)
         SEQ_SYS: begin
            if (cnt_r == SEQ_CNT_W'(SYS_TO_PWR_CYC - 1)) begin
               seq_nxt = SEQ_PWR;
               cnt_nxt = '0;
            end else begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         SEQ_PWR: begin
            // The count starts over while the pin is still held.
            if (!rst_pin_s_n) begin
               cnt_nxt = '0;
            end else if (cnt_r == SEQ_CNT_W'(PWR_TO_REL_CYC - 1)) begin
               seq_nxt = SEQ_RUN;
            end else begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         SEQ_RUN: begin
            if (!rst_pin_s_n) begin
               seq_nxt = SEQ_SYS;
               cnt_nxt = '0;
            end
         end
         default: begin
            seq_nxt = SEQ_SYS;
            cnt_nxt = '0;
         end
      endcase
      system_enable_out_nxt = 1'b1;
      power_enable_out_nxt = power_enable_out | (seq_nxt != SEQ_SYS);
      irst_n_nxt = (seq_nxt == SEQ_RUN);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         seq_r               <= SEQ_SYS;
         cnt_r               <= '0;
         system_enable_out   <= 1'b0;
         power_enable_out    <= 1'b0;
         internal_resetn_out <= 1'b0;
      end else begin
         seq_r               <= seq_nxt;
         cnt_r               <= cnt_nxt;
         system_enable_out   <= system_enable_out_nxt;
         power_enable_out    <= power_enable_out_nxt;
         internal_resetn_out <= irst_n_nxt;
      end
   end

   // Register file and hold state.
   logic                  rdh_r, rdh_nxt;
   logic                  perh_r, perh_nxt;
   logic                  smf_r, smf_nxt;
   logic                  pcf_r, pcf_nxt;
   logic                  sub_a_r, sub_a_nxt;
   logic                  sub_b_r, sub_b_nxt;
   logic                  pce_r, pce_nxt;
   logic                  tce_r, tce_nxt;
   logic [31:0]           sst_r [SST_COUNT];
   logic [31:0]           sst_nxt [SST_COUNT];
   logic                  lp_d_r;
   logic [GPIO_COUNT-1:0] hold_val_r, hold_val_nxt;
   logic [GPIO_COUNT-1:0] hold_oe_r, hold_oe_nxt;
   logic [31:0]           prdata_nxt;
   logic                  pready_nxt, pslverr_nxt;
   logic                  low_power, lp_entry, hold_set, wr_en;
   logic [1:0]            sst_idx;

   assign low_power = sleep_req | deep_sleep_req;
   assign lp_entry  = low_power & ~lp_d_r;
   assign hold_set  = lp_entry | (seq_r != SEQ_RUN);
   assign wr_en     = psel & penable & pready & pwrite & ~pslverr;
   assign sst_idx   = paddr[3:2];

   // Bus decode, write effects and hold capture.
   always_comb begin
      rdh_nxt      = rdh_r;
      perh_nxt     = perh_r;
      smf_nxt      = smf_r;
      pcf_nxt      = pcf_r;
      sub_a_nxt    = sub_a_r;
      sub_b_nxt    = sub_b_r;
      pce_nxt      = pce_r;
      tce_nxt      = tce_r;
      sst_nxt      = sst_r;
      hold_val_nxt = hold_val_r;
      hold_oe_nxt  = hold_oe_r;
      prdata_nxt   = prdata;
      pslverr_nxt  = pslverr;
      // Answer in the first access cycle.
      pready_nxt   = psel & ~penable & ~pready;
      if (psel && !penable) begin
         pslverr_nxt = ~addr_hit(paddr);
         prdata_nxt  = 32'h0000_0000;
         case (paddr)
            ADDR_SLEEP_STATUS: begin
               prdata_nxt[SSR_SLEEP_BIT] = sleep_req;
               prdata_nxt[SSR_DEEP_BIT]  = deep_sleep_req;
               prdata_nxt[SSR_RDH_BIT]   = rdh_r;
               prdata_nxt[SSR_PERH_BIT]  = perh_r;
            end
            ADDR_POWER_CFG: begin
               prdata_nxt[PCR_SMF_BIT] = smf_r;
               prdata_nxt[PCR_PCF_BIT] = pcf_r;
            end
            ADDR_SUB_PIN_CTRL: begin
               prdata_nxt[SUB_A_BIT] = sub_a_r;
               prdata_nxt[SUB_B_BIT] = sub_b_r;
            end
            ADDR_OSC_CFG: begin
               prdata_nxt[OSC_PCE_BIT] = pce_r;
               prdata_nxt[OSC_TCE_BIT] = tce_r;
            end
            default: begin
               if (addr_hit(paddr)) begin
                  prdata_nxt = sst_r[sst_idx];
               end
            end
         endcase
      end
      if (wr_en) begin
         case (paddr)
            ADDR_SLEEP_STATUS: begin
               // Writing one clears a hold bit.
               if (pwdata[SSR_RDH_BIT]) begin
                  rdh_nxt = 1'b0;
               end
               if (pwdata[SSR_PERH_BIT]) begin
                  perh_nxt = 1'b0;
               end
            end
            ADDR_POWER_CFG: begin
               smf_nxt = pwdata[PCR_SMF_BIT];
               pcf_nxt = pwdata[PCR_PCF_BIT];
            end
            ADDR_SUB_PIN_CTRL: begin
               sub_a_nxt = pwdata[SUB_A_BIT];
               sub_b_nxt = pwdata[SUB_B_BIT];
            end
            ADDR_OSC_CFG: begin
               pce_nxt = pwdata[OSC_PCE_BIT];
               tce_nxt = pwdata[OSC_TCE_BIT];
            end
            default: begin
               sst_nxt[sst_idx] = pwdata;
            end
         endcase
      end
      // A set in the same cycle as a clear wins.
      if (hold_set) begin
         rdh_nxt  = 1'b1;
         perh_nxt = 1'b1;
      end
      // Sleep entry captures the sleep-state value and the pin direction.
      if (lp_entry) begin
         for (int i = 0; i < SST_COUNT; i++) begin
            hold_val_nxt[i*32 +: 32] = sst_r[i];
         end
         hold_oe_nxt = gpio_dir;
      end
      // Any internal reset leaves every GPIO pin not under power manager override an input.
      if (seq_r != SEQ_RUN) begin
         hold_oe_nxt = '0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdh_r      <= HOLD_RESET;
         perh_r     <= HOLD_RESET;
         smf_r      <= 1'b0;
         pcf_r      <= 1'b0;
         sub_a_r    <= 1'b0;
         sub_b_r    <= 1'b0;
         pce_r      <= 1'b0;
         tce_r      <= 1'b0;
         for (int i = 0; i < SST_COUNT; i++) begin
            sst_r[i] <= SST_RESET;
         end
         lp_d_r     <= 1'b0;
         hold_val_r <= '0;
         hold_oe_r  <= '0;
         prdata     <= 32'h0000_0000;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
      end else begin
         rdh_r      <= rdh_nxt;
         perh_r     <= perh_nxt;
         smf_r      <= smf_nxt;
         pcf_r      <= pcf_nxt;
         sub_a_r    <= sub_a_nxt;
         sub_b_r    <= sub_b_nxt;
         pce_r      <= pce_nxt;
         tce_r      <= tce_nxt;
         sst_r      <= sst_nxt;
         lp_d_r     <= low_power;
         hold_val_r <= hold_val_nxt;
         hold_oe_r  <= hold_oe_nxt;
         prdata     <= prdata_nxt;
         pready     <= pready_nxt;
         pslverr    <= pslverr_nxt;
      end
   end

   // Per-pin float in sleep; the timer group floats in sleep while os_timer_active is high.
   logic [GPIO_COUNT-1:0] sleep_float;
   logic                  clk_ovr, sub_ovr, lp_hold;
   assign sleep_float = ({GPIO_COUNT{smf_r}} & STATIC_MEM_MASK) |
                        ({GPIO_COUNT{pcf_r}} & PC_CARD_MASK) |
                        ({GPIO_COUNT{os_timer_active}} & TIMER_STOP_MASK);
   assign clk_ovr = pce_r | tce_r;
   assign sub_ovr = sub_a_r | sub_b_r;
   assign lp_hold = low_power | perh_r;

   // One registered pad cell per pin, with the forced functions decoded here.
   for (genvar g = 0; g < GPIO_COUNT; g++) begin : g_pin
      logic fen;
      logic fval;
      if (g == PIN_PROG_CLK) begin : g_pclk
         assign fen  = clk_ovr;
         assign fval = prog_clock_out;
      end else if (g == PIN_TIMER_CLK) begin : g_tclk
         assign fen  = clk_ovr;
         assign fval = timer_clock_out;
      end else if (g == PIN_SUB_A || g == PIN_SUB_B) begin : g_sub
         assign fen  = sub_ovr;
         assign fval = subscriber_enable;
      end else begin : g_none
         assign fen  = 1'b0;
         assign fval = 1'b0;
      end
      psrc_pin_cell u_cell (
         .ref_clk     (ref_clk),
         .rst_n       (rst_n),
         .pm_ovr      (pm_override[g]),
         .pm_out      (pm_out[g]),
         .pm_oe       (pm_oe[g]),
         .low_power   (lp_hold),
         .in_sleep    (low_power),
         .sleep_float (sleep_float[g]),
         .hold_val    (hold_val_nxt[g]),
         .hold_oe     (hold_oe_nxt[g]),
         .read_disable_hold         (rdh_r),
         .pull_up_def (PULL_UP_MASK[g]),
         .pull_dn_def (PULL_DN_MASK[g]),
         .force_en    (fen),
         .force_val   (fval),
         .alt_sel     (alt_sel[g]),
         .alt_out     (alt_out[g]),
         .alt_oe      (alt_oe[g]),
         .gpio_dir    (gpio_dir[g]),
         .gpio_out    (gpio_out[g]),
         .pad_out     (pad_out[g]),
         .pad_oe      (pad_oe[g]),
         .pad_ie      (pad_ie[g]),
         .pad_pu      (pad_pu[g]),
         .pad_pd      (pad_pd[g])
      );
   end

   // Non-GPIO memory control pins: only the static float bit stops their drive in sleep.
   logic [MEM_PINS-1:0] mem_oe_nxt;
   assign mem_oe_nxt = mem_ctl_oe & ~{MEM_PINS{low_power & smf_r}};

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_pad_out <= '0;
         mem_pad_oe  <= '0;
      end else begin
         mem_pad_out <= mem_ctl_out;
         mem_pad_oe  <= mem_oe_nxt;
      end
   end

endmodule // psrc_top

// File: dv/psrc_sva.sv
// Purpose: Port-level checker for pad sleep and reset state control.
// Assumes: Bound to psrc_top; one clock domain.
// Notes:   Sees the top ports only; register bits are inferred from pad behaviour.
`timescale 1ns/1ns
module psrc_sva (
   input wire logic         ref_clk,
   input wire logic         resetn,
   input wire logic         sleep_req,
   input wire logic         deep_sleep_req,
   input wire logic [127:0] pm_override,
   input wire logic [127:0] pm_oe,
   input wire logic [127:0] gpio_dir,
   input wire logic [3:0]   mem_ctl_oe,
   input wire logic [127:0] pad_out,
   input wire logic [127:0] pad_oe,
   input wire logic [127:0] pad_ie,
   input wire logic [127:0] pad_pu,
   input wire logic [127:0] pad_pd,
   input wire logic [3:0]   mem_pad_oe,
   input wire logic         system_enable_out,
   input wire logic         power_enable_out,
   input wire logic         internal_resetn_out
);
   // All checks share the block clock and its reset.
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   chk_pwr_after_sys: assert property ($rose(power_enable_out) |-> $past(system_enable_out, 19))
      else $error("power enable rose too soon after system enable");
   chk_int_after_pwr: assert property (internal_resetn_out |-> power_enable_out && system_enable_out)
      else $error("internal reset released before power enable");
   chk_rst_undriven: assert property (!internal_resetn_out && $past(!internal_resetn_out) |=>
      (pad_oe & ~$past(pm_override)) == '0) else $error("pin driven during reset");
   chk_rst_no_input: assert property (!internal_resetn_out && $past(!internal_resetn_out) |=>
      (pad_ie & ~$past(pm_override)) == '0) else $error("input buffer on during reset");
   chk_pm_pull_off: assert property (((pad_pu | pad_pd) & $past(pm_override)) == '0)
      else $error("pull left on under power manager override");
   chk_pm_input_en: assert property (((pad_ie ^ ~$past(pm_oe)) & $past(pm_override)) == '0)
      else $error("input buffer ignores power manager override");
   chk_sleep_in_float: assert property ($rose(sleep_req | deep_sleep_req) |=>
      (pad_oe & ~$past(gpio_dir) & ~$past(pm_override)) == '0) else $error("input pin driven in sleep");
   chk_sleep_hold: assert property (sleep_req && $past(sleep_req) && pm_override == '0 &&
      $past(pm_override) == '0 |=> $stable(pad_out)) else $error("sleep value not held");
   chk_mem_pass: assert property (internal_resetn_out && $past(internal_resetn_out) &&
      !$past(sleep_req | deep_sleep_req) |-> mem_pad_oe == $past(mem_ctl_oe)) else $error("memory pin enable lost");

   // Main scenarios reached by the bench.
   cov_sleep: cover property ($rose(sleep_req));
   cov_pm: cover property (pm_override != '0);
   cov_pwr: cover property ($rose(power_enable_out));
endmodule // psrc_sva

bind psrc_top psrc_sva chk_u (.ref_clk(ref_clk), .resetn(resetn), .sleep_req(sleep_req),
   .deep_sleep_req(deep_sleep_req), .pm_override(pm_override), .pm_oe(pm_oe), .gpio_dir(gpio_dir),
   .mem_ctl_oe(mem_ctl_oe), .pad_out(pad_out), .pad_oe(pad_oe), .pad_ie(pad_ie), .pad_pu(pad_pu),
   .pad_pd(pad_pd), .mem_pad_oe(mem_pad_oe), .system_enable_out(system_enable_out),
   .power_enable_out(power_enable_out), .internal_resetn_out(internal_resetn_out));

// File: dv/tb.sv
// Purpose: Self-checking bench for pad sleep and reset state control.
// Assumes: 20 MHz clock, APB registers answering with no wait states.
// Notes:   Float masks put pins 0, 1 and 2 in the float groups, pin 3 pulls up.
`timescale 1ns/1ns
module tb;
   import psrc_pkg::*;
   logic           ref_clk = 1'b0, resetn = 1'b0, reset_pin_n = 1'b1;
   logic           psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [11:0]    paddr = '0;
   logic [31:0]    pwdata = '0, prdata, sst;
   logic           sleep_req = 1'b0, deep_sleep_req = 1'b0, os_timer_active = 1'b0;
   logic           prog_clock_out = 1'b0, timer_clock_out = 1'b0, subscriber_enable = 1'b0;
   logic [127:0]   pm_override = '0, pm_out = '0, pm_oe = '0, gpio_dir = '0, gpio_out = '0;
   logic [127:0]   alt_sel = '0, alt_out = '0, alt_oe = '0, pad_out, pad_oe, pad_ie, pad_pu, pad_pd;
   logic [3:0]     mem_ctl_out = '0, mem_ctl_oe = '0, mem_pad_out, mem_pad_oe;
   logic           system_enable_out, power_enable_out, internal_resetn_out;
   logic [33:0]    exp_q[$];
   logic [33:0]    exp_e;
   int             err_total = 0, check_count = 0, cyc = 0, n;
   integer         seed = 32'h2c16;

   psrc_top #(.PULL_UP_MASK(128'h8), .PULL_DN_MASK(128'h10), .STATIC_MEM_MASK(128'h1), .PC_CARD_MASK(128'h2),
      .TIMER_STOP_MASK(128'h4)) dut_u (.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .reset_pin_n, .sleep_req, .deep_sleep_req, .os_timer_active,
      .pm_override, .pm_out, .pm_oe, .gpio_dir, .gpio_out, .alt_sel, .alt_out, .alt_oe, .prog_clock_out,
      .timer_clock_out, .subscriber_enable, .mem_ctl_out, .mem_ctl_oe, .pad_out, .pad_oe, .pad_ie,
      .pad_pu, .pad_pd, .mem_pad_out, .mem_pad_oe, .system_enable_out, .power_enable_out,
      .internal_resetn_out);

   // Clock at 50 ns period.
   always #25 ref_clk = ~ref_clk;

   task automatic chk(input string nm, input logic [127:0] ex, input logic [127:0] got);
      check_count++;
      if (got !== ex) begin
         err_total++;
         $display("unexpected %s exp %h got %h", nm, ex, got);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // One APB transfer; e holds {is_read, error, data} for the monitor.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      exp_q.push_back(e);
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Pads answer one cycle after their cause; wait a little more and look mid-cycle.
   task automatic settle;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   function automatic logic [127:0] r128;
      return {$random(seed), $random(seed), $random(seed), $random(seed)};
   endfunction

   // Completed APB transfers are compared with the oldest note.
   always @(posedge ref_clk) begin
      if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
         exp_e = exp_q.pop_front();
         chk("pslverr", exp_e[32], pslverr);
         if (exp_e[33]) chk("prdata", exp_e[31:0], prdata);
      end
   end

   // A hang is cut short well beyond the 150 or so cycles needed.
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         stop_test();
      end
   end

   initial begin
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      for (n = 0; n < 300 && internal_resetn_out !== 1'b1; n++) @(posedge ref_clk);
      settle();
      chk("rst_oe", 0, pad_oe);
      chk("rst_pull", 128'h8, pad_pu);
      chk("rst_pd", 128'h10, pad_pd);
      apb(0, ADDR_SLEEP_STATUS, 0, {2'b10, 32'h30});
      apb(0, 12'h020, 0, {2'b11, 32'h0});
      apb(0, ADDR_SLEEP_STATE0, 0, {2'b10, SST_RESET});
      $display("test reset done");
      gpio_dir <= r128();
      gpio_out <= r128();
      apb(1, ADDR_SLEEP_STATUS, 32'h30, 34'h0);
      settle();
      chk("run_out", gpio_out & gpio_dir, pad_out & gpio_dir);
      chk("run_ie", ~gpio_dir, pad_ie);
      sst = $random(seed);
      apb(1, ADDR_SLEEP_STATE0, sst, 34'h0);
      apb(0, ADDR_SLEEP_STATE0, 0, {2'b10, sst});
      sleep_req <= 1'b1;
      settle();
      chk("slp_out", sst & gpio_dir[31:0], pad_out[31:0] & gpio_dir[31:0]);
      chk("slp_oe", gpio_dir, pad_oe);
      chk("slp_ie", 0, pad_ie);
      @(posedge ref_clk);
      sleep_req <= 1'b0;
      gpio_out <= ~gpio_out;
      settle();
      chk("wake_out", sst & gpio_dir[31:0], pad_out[31:0] & gpio_dir[31:0]);
      apb(0, ADDR_SLEEP_STATUS, 0, {2'b10, 32'h30});
      apb(1, ADDR_SLEEP_STATUS, 32'h20, 34'h0);
      settle();
      chk("free_out", gpio_out & gpio_dir, pad_out & gpio_dir);
      chk("wake_ie", 0, pad_ie);
      apb(1, ADDR_SLEEP_STATUS, 32'h10, 34'h0);
      settle();
      chk("free_ie", ~gpio_dir, pad_ie);
      $display("test sleep done");
      gpio_dir <= '1;
      os_timer_active <= 1'b1;
      {mem_ctl_oe, mem_ctl_out} <= {4'hf, 4'($random(seed))};
      apb(1, ADDR_POWER_CFG, 32'h3, 34'h0);
      deep_sleep_req <= 1'b1;
      settle();
      chk("float_oe", 4'h8, pad_oe[3:0]);
      chk("mem_oe", 0, mem_pad_oe);
      chk("deep_ie", 0, pad_ie);
      @(posedge ref_clk);
      deep_sleep_req <= 1'b0;
      apb(1, ADDR_POWER_CFG, 32'h0, 34'h0);
      apb(1, ADDR_SLEEP_STATUS, 32'h30, 34'h0);
      settle();
      chk("mem_run", {4'hf, mem_ctl_out}, {mem_pad_oe, mem_pad_out});
      $display("test float done");
      alt_sel <= '1;
      alt_out <= r128();
      alt_oe <= '1;
      {prog_clock_out, timer_clock_out, subscriber_enable} <= 3'($random(seed));
      apb(1, ADDR_OSC_CFG, 32'h1, 34'h0);
      apb(1, ADDR_SUB_PIN_CTRL, 32'h2, 34'h0);
      settle();
      chk("forced", {subscriber_enable, subscriber_enable, timer_clock_out, prog_clock_out},
         {pad_out[115:114], pad_out[10:9]});
      chk("alt", alt_out[63:11], pad_out[63:11]);
      pm_override <= r128();
      pm_out <= r128();
      settle();
      chk("pm_out", pm_out & pm_override, pad_out & pm_override);
      chk("pm_pull", 0, (pad_pu | pad_pd) & pm_override);
      $display("test override done");
      stop_test();
   end
endmodule // tb
